// file: core/frm_mem.sv
// Memory end of the link: slave decoder, address counter and array.
//
// Summary of operation
// - Works with SCL up to 3.4 MHz.
// - Master sends high-speed code before fast commands.
// - High-speed mode holds across restarts until stop.
// - Random read: write address, restart, read, nack.
// - Master ack without stop fetches next byte.
// - Address wraps from top location to zero.
// - Read with no address uses internal address.
// - Address register holds last access plus one.
// - Master finishes prior transfer with stop first.
// - Address register is undefined after power-up.
// - Master keeps both lines high around power cycling.
// - Master nack ends output; wait for stop.
// - Slave byte: type code, select pins, direction.
// - Thirteen address bits cover 8192 bytes.
`timescale 1ns/1ns
`include "frm_params.svh"
module frm_mem #(
	// Device type code; the value is arbitrary.
	parameter logic [3:0] DEV_TYPE = 4'h6
) (
	input wire logic clk,
	input wire logic srst,
	frm_if.mem bus,
	input wire logic [2:0] chip_select_pins,
	input wire logic load_en,
	input wire logic [`FRM_AW-1:0] load_addr,
	input wire logic [7:0] load_data,
	output logic hs_mode,
	output logic active
);
	// ============================================================
	// Line sampling
	logic [2:0] scl_sy;
	logic [2:0] sda_sy;
	logic scl_f;
	logic sda_f;
	logic scl_q;
	logic sda_q;
	logic [2:0] next_scl_sy;
	logic [2:0] next_sda_sy;
	logic next_scl_f;
	logic next_sda_f;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	// Oversampling at the system clock keeps up with the fastest SCL.
	always_comb begin
		next_scl_sy = {scl_sy[1:0], bus.scl};
		next_sda_sy = {sda_sy[1:0], bus.sda};
		next_scl_f = (scl_sy[1] == scl_sy[2]) ? scl_sy[2] : scl_f;
		next_sda_f = (sda_sy[1] == sda_sy[2]) ? sda_sy[2] : sda_f;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			scl_sy <= 3'h7;
			sda_sy <= 3'h7;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_sy <= next_scl_sy;
			sda_sy <= next_sda_sy;
			scl_f <= next_scl_f;
			sda_f <= next_sda_f;
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	assign scl_rise = scl_f & ~scl_q;
	assign scl_fall = ~scl_f & scl_q;
	assign start_seen = scl_f & scl_q & sda_q & ~sda_f;
	assign stop_seen = scl_f & scl_q & ~sda_q & sda_f;

	// ============================================================
	// Array and address counter
	logic [7:0] mem [0:`FRM_DEPTH-1];
	logic [`FRM_AW-1:0] addr;
	logic [`FRM_AW-1:0] next_addr;
	logic addr_we;
	logic mem_we;
	logic [7:0] rd_byte;
	logic [7:0] shreg;

	assign rd_byte = mem[addr];

	// The preload port wins over a bus write in the same cycle.
	always_ff @(posedge clk) begin
		if (load_en) begin
			mem[load_addr] <= load_data;
		end else if (mem_we) begin
			mem[addr] <= shreg;
		end
	end

	// No reset: the counter has no known value until an addressed access.
	always_ff @(posedge clk) begin
		if (addr_we) begin
			addr <= next_addr;
		end
	end

	// ============================================================
	// Protocol engine
	frm_pkg::frm_dstate_t state;
	frm_pkg::frm_dstate_t next_state;
	frm_pkg::frm_kind_t kind;
	frm_pkg::frm_kind_t next_kind;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic [7:0] next_shreg;
	logic [`FRM_HI_BITS-1:0] whi;
	logic [`FRM_HI_BITS-1:0] next_whi;
	logic rw;
	logic next_rw;
	logic drive;
	logic next_drive;
	logic hs;
	logic next_hs;
	logic load_tx;
	logic do_ack;

	always_comb begin
		next_state = state;
		next_kind = kind;
		next_cnt = cnt;
		next_shreg = shreg;
		next_whi = whi;
		next_rw = rw;
		next_drive = drive;
		next_hs = hs;
		next_addr = addr;
		addr_we = 1'b0;
		mem_we = 1'b0;
		load_tx = 1'b0;
		do_ack = 1'b0;
		if (stop_seen) begin
			next_state = frm_pkg::D_IDLE;
			next_drive = 1'b0;
			next_hs = 1'b0;
		end else if (start_seen) begin
			// A repeated start leaves the speed mode alone.
			next_state = frm_pkg::D_RX;
			next_kind = frm_pkg::K_SLAVE;
			next_cnt = 4'h0;
			next_drive = 1'b0;
		end else begin
			case (state)
				frm_pkg::D_RX: begin
					if (scl_rise) begin
						next_shreg = {shreg[6:0], sda_f};
						next_cnt = cnt + 4'h1;
					end else if (scl_fall && cnt == `FRM_BYTE_BITS) begin
						case (kind)
							frm_pkg::K_SLAVE: begin
								if (shreg[7:3] == `FRM_HS_CODE) begin
									next_hs = 1'b1;
									next_state = frm_pkg::D_WAIT;
								end else if (shreg[7:4] == DEV_TYPE &&
									shreg[3:1] == chip_select_pins) begin
									next_rw = shreg[0];
									do_ack = 1'b1;
								end else begin
									next_state = frm_pkg::D_WAIT;
								end
							end
							frm_pkg::K_WHI: begin
								next_whi = shreg[`FRM_HI_BITS-1:0];
								do_ack = 1'b1;
							end
							frm_pkg::K_WLO: begin
								next_addr = {whi, shreg};
								addr_we = 1'b1;
								do_ack = 1'b1;
							end
							default: begin
								mem_we = 1'b1;
								next_addr = addr + 13'h0001;
								addr_we = 1'b1;
								do_ack = 1'b1;
							end
						endcase
					end
				end
				frm_pkg::D_ACK: begin
					if (scl_fall) begin
						next_drive = 1'b0;
						if (rw == `FRM_DIR_RD) begin
							load_tx = 1'b1;
						end else begin
							next_state = frm_pkg::D_RX;
							next_cnt = 4'h0;
							case (kind)
								frm_pkg::K_SLAVE: next_kind = frm_pkg::K_WHI;
								frm_pkg::K_WHI: next_kind = frm_pkg::K_WLO;
								default: next_kind = frm_pkg::K_WDATA;
							endcase
						end
					end
				end
				frm_pkg::D_TX: begin
					if (scl_fall) begin
						if (cnt == `FRM_BYTE_BITS) begin
							next_drive = 1'b0;
							next_state = frm_pkg::D_RACK;
						end else begin
							next_shreg = {shreg[6:0], 1'b0};
							next_drive = ~shreg[6];
							next_cnt = cnt + 4'h1;
						end
					end
				end
				frm_pkg::D_RACK: begin
					if (scl_rise) begin
						if (!sda_f) begin
							// Next byte goes out on the following fall.
							next_state = frm_pkg::D_ACK;
						end else begin
							next_state = frm_pkg::D_WAIT;
						end
					end
				end
				default: begin
				end
			endcase
		end
		if (do_ack) begin
			next_drive = 1'b1;
			next_state = frm_pkg::D_ACK;
		end
		if (load_tx) begin
			// The increment wraps at the top of the 13-bit space.
			next_shreg = rd_byte;
			next_drive = ~rd_byte[7];
			next_cnt = 4'h1;
			next_addr = addr + 13'h0001;
			addr_we = 1'b1;
			next_state = frm_pkg::D_TX;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= frm_pkg::D_IDLE;
			kind <= frm_pkg::K_SLAVE;
			cnt <= 4'h0;
			shreg <= 8'h00;
			whi <= 5'h00;
			rw <= 1'b0;
			drive <= 1'b0;
			hs <= 1'b0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			cnt <= next_cnt;
			shreg <= next_shreg;
			whi <= next_whi;
			rw <= next_rw;
			drive <= next_drive;
			hs <= next_hs;
		end
	end

	// ============================================================
	// Outputs
	assign bus.d_sda_o = 1'b0;
	assign bus.d_sda_oe = drive;
	assign hs_mode = hs;
	assign active = (state != frm_pkg::D_IDLE);
endmodule

// file: core/frm_params.svh
// Timing, field and encoding constants shared by both ends of the link.
`ifndef FRM_PARAMS_SVH
`define FRM_PARAMS_SVH

// ============================================================
// Clock rates
`define FRM_CLK_KHZ 100000
`define FRM_FS_SCL_KHZ 400
`define FRM_HS_SCL_KHZ 3400
// Quarter bit periods in system clocks, rounded up so SCL never runs fast.
`define FRM_FS_QTR ((`FRM_CLK_KHZ+4*`FRM_FS_SCL_KHZ-1)/(4*`FRM_FS_SCL_KHZ))
`define FRM_HS_QTR ((`FRM_CLK_KHZ+4*`FRM_HS_SCL_KHZ-1)/(4*`FRM_HS_SCL_KHZ))

// ============================================================
// Array and framing
`define FRM_AW 13
`define FRM_DEPTH 8192
`define FRM_HI_BITS 5
`define FRM_BYTE_BITS 4'h8
`define FRM_HS_CODE 5'h01
`define FRM_HS_LOW 3'h1
`define FRM_DIR_RD 1'h1
`define FRM_DIR_WR 1'h0

`endif

// file: core/frm_pkg.sv
// State and sequence types for both ends of the memory link.
package frm_pkg;

	// ============================================================
	// Memory end
	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_RX = 3'h1,
		D_ACK = 3'h2,
		D_TX = 3'h3,
		D_RACK = 3'h4,
		D_WAIT = 3'h5
	} frm_dstate_t;

	typedef enum logic [1:0] {
		K_SLAVE = 2'h0,
		K_WHI = 2'h1,
		K_WLO = 2'h2,
		K_WDATA = 2'h3
	} frm_kind_t;

	// ============================================================
	// Master end
	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_START = 2'h1,
		M_BIT = 2'h2,
		M_STOP = 2'h3
	} frm_mstate_t;

	typedef enum logic [2:0] {
		SQ_HSCODE = 3'h0,
		SQ_SLW = 3'h1,
		SQ_AHI = 3'h2,
		SQ_ALO = 3'h3,
		SQ_SLR = 3'h4,
		SQ_DATA = 3'h5
	} frm_step_t;

endpackage

// file: core/frm_if.sv
// Two-wire link between the bus master and the memory end.
`timescale 1ns/1ns
interface frm_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	wire scl;
	wire sda;

	// ============================================================
	// Wired-AND of the open-drain drivers with a pull-up.
	assign scl = ~(m_scl_oe & ~m_scl_o);
	assign sda = ~(m_sda_oe & ~m_sda_o) & ~(d_sda_oe & ~d_sda_o);

	modport master (
		input scl,
		input sda,
		output m_scl_o,
		output m_scl_oe,
		output m_sda_o,
		output m_sda_oe
	);

	modport mem (
		input scl,
		input sda,
		output d_sda_o,
		output d_sda_oe
	);
endinterface

// file: core/frm_master.sv
// Bus master end: issues random and current-address reads on the link.
`timescale 1ns/1ns
`include "frm_params.svh"
module frm_master #(
	// Device type code; the value is arbitrary.
	parameter logic [3:0] DEV_TYPE = 4'h6
) (
	input wire logic clk,
	input wire logic srst,
	frm_if.master bus,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_random,
	input wire logic cmd_hs,
	input wire logic [2:0] cmd_cs,
	input wire logic [`FRM_AW-1:0] cmd_addr,
	input wire logic [7:0] cmd_len,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic done,
	output logic nack_err
);
	// ============================================================
	// Byte to send for each step of a command
	function automatic logic [7:0] tx_byte(input frm_pkg::frm_step_t s,
		input logic [2:0] cs, input logic [`FRM_AW-1:0] a);
		case (s)
			frm_pkg::SQ_HSCODE: tx_byte = {`FRM_HS_CODE, `FRM_HS_LOW};
			frm_pkg::SQ_SLW: tx_byte = {DEV_TYPE, cs, `FRM_DIR_WR};
			frm_pkg::SQ_AHI: tx_byte = {3'h0, a[`FRM_AW-1:8]};
			frm_pkg::SQ_ALO: tx_byte = a[7:0];
			frm_pkg::SQ_SLR: tx_byte = {DEV_TYPE, cs, `FRM_DIR_RD};
			default: tx_byte = 8'hFF;
		endcase
	endfunction

	frm_pkg::frm_mstate_t state, next_state;
	frm_pkg::frm_step_t step, next_step;
	logic [1:0] ph, next_ph;
	logic [3:0] bcnt, next_bcnt;
	logic [6:0] div, next_div, reload;
	logic hs, next_hs, random, next_random;
	logic [2:0] cs, next_cs;
	logic [`FRM_AW-1:0] addr, next_addr;
	logic [7:0] remain, next_remain, rxb, next_rxb;
	logic [7:0] next_rd_data;
	logic ackbit, next_ackbit, scl_low, next_scl_low;
	logic sda_low, next_sda_low, next_rd_valid, next_done, next_err;
	logic [2:0] sda_sy;
	logic sda_f, next_sda_f, tick, txbit;
	logic [7:0] cur_byte;

	assign reload = hs ? 7'(`FRM_HS_QTR - 1) : 7'(`FRM_FS_QTR - 1);
	assign tick = (state != frm_pkg::M_IDLE) && (div == 7'h00);
	assign next_sda_f = (sda_sy[1] == sda_sy[2]) ? sda_sy[2] : sda_f;
	assign cur_byte = tx_byte(step, cs, addr);
	assign txbit = cur_byte[3'h7 - bcnt[2:0]];

	always_comb begin
		next_state = state;
		next_step = step;
		next_ph = ph;
		next_bcnt = bcnt;
		next_div = (div == 7'h00) ? reload : div - 7'h01;
		next_hs = hs;
		next_random = random;
		next_cs = cs;
		next_addr = addr;
		next_remain = remain;
		next_rxb = rxb;
		next_rd_data = rd_data;
		next_ackbit = ackbit;
		next_scl_low = scl_low;
		next_sda_low = sda_low;
		next_rd_valid = 1'b0;
		next_done = 1'b0;
		next_err = nack_err;
		if (state == frm_pkg::M_IDLE) begin
			// Idle leaves both lines released high.
			next_scl_low = 1'b0;
			next_sda_low = 1'b0;
			next_div = reload;
			if (cmd_valid) begin
				next_random = cmd_random;
				next_cs = cmd_cs;
				next_addr = cmd_addr;
				next_remain = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
				next_err = 1'b0;
				next_ph = 2'h0;
				next_state = frm_pkg::M_START;
				if (cmd_hs) begin
					next_step = frm_pkg::SQ_HSCODE;
				end else if (cmd_random) begin
					next_step = frm_pkg::SQ_SLW;
				end else begin
					next_step = frm_pkg::SQ_SLR;
				end
			end
		end else if (tick) begin
			next_ph = ph + 2'h1;
			case (state)
				frm_pkg::M_START: begin
					case (ph)
						2'h0: next_sda_low = 1'b0;
						2'h1: next_scl_low = 1'b0;
						2'h2: next_sda_low = 1'b1;
						default: begin
							next_scl_low = 1'b1;
							next_bcnt = 4'h0;
							next_state = frm_pkg::M_BIT;
						end
					endcase
				end
				frm_pkg::M_BIT: begin
					case (ph)
						2'h0: begin
							if (bcnt < `FRM_BYTE_BITS) begin
								next_sda_low = (step != frm_pkg::SQ_DATA) && !txbit;
							end else begin
								// Ack every byte but the last, then nack it.
								next_sda_low = (step == frm_pkg::SQ_DATA) &&
									(remain != 8'h01);
							end
						end
						2'h1: next_scl_low = 1'b0;
						2'h2: begin
							if (bcnt < `FRM_BYTE_BITS) begin
								next_rxb = {rxb[6:0], sda_f};
							end else begin
								next_ackbit = sda_f;
							end
						end
						default: begin
							next_scl_low = 1'b1;
							next_bcnt = bcnt + 4'h1;
							if (bcnt == `FRM_BYTE_BITS) begin
								next_bcnt = 4'h0;
								if (step == frm_pkg::SQ_HSCODE) begin
									// The code draws no ack; speed up from the restart.
									next_hs = 1'b1;
									next_state = frm_pkg::M_START;
									next_step = random ? frm_pkg::SQ_SLW :
										frm_pkg::SQ_SLR;
								end else if (step == frm_pkg::SQ_DATA) begin
									next_rd_valid = 1'b1;
									next_rd_data = rxb;
									next_remain = remain - 8'h01;
									if (remain == 8'h01) begin
										next_state = frm_pkg::M_STOP;
									end
								end else if (ackbit) begin
									next_err = 1'b1;
									next_state = frm_pkg::M_STOP;
								end else if (step == frm_pkg::SQ_ALO) begin
									next_state = frm_pkg::M_START;
									next_step = frm_pkg::SQ_SLR;
								end else if (step == frm_pkg::SQ_SLR) begin
									next_step = frm_pkg::SQ_DATA;
								end else begin
									next_step = frm_pkg::frm_step_t'(step + 3'h1);
								end
							end
						end
					endcase
				end
				default: begin
					case (ph)
						2'h0: next_sda_low = 1'b1;
						2'h1: next_scl_low = 1'b0;
						2'h2: next_sda_low = 1'b0;
						default: begin
							next_hs = 1'b0;
							next_done = 1'b1;
							next_state = frm_pkg::M_IDLE;
						end
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= frm_pkg::M_IDLE;
			step <= frm_pkg::SQ_SLR;
			ph <= 2'h0;
			bcnt <= 4'h0;
			div <= 7'h00;
			hs <= 1'b0;
			random <= 1'b0;
			cs <= 3'h0;
			addr <= 13'h0000;
			remain <= 8'h00;
			rxb <= 8'h00;
			rd_data <= 8'h00;
			ackbit <= 1'b1;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			rd_valid <= 1'b0;
			done <= 1'b0;
			nack_err <= 1'b0;
			sda_sy <= 3'h7;
			sda_f <= 1'b1;
		end else begin
			state <= next_state;
			step <= next_step;
			ph <= next_ph;
			bcnt <= next_bcnt;
			div <= next_div;
			hs <= next_hs;
			random <= next_random;
			cs <= next_cs;
			addr <= next_addr;
			remain <= next_remain;
			rxb <= next_rxb;
			rd_data <= next_rd_data;
			ackbit <= next_ackbit;
			scl_low <= next_scl_low;
			sda_low <= next_sda_low;
			rd_valid <= next_rd_valid;
			done <= next_done;
			nack_err <= next_err;
			sda_sy <= {sda_sy[1:0], bus.sda};
			sda_f <= next_sda_f;
		end
	end

	assign cmd_ready = (state == frm_pkg::M_IDLE);
	assign bus.m_scl_o = 1'b0;
	assign bus.m_scl_oe = scl_low;
	assign bus.m_sda_o = 1'b0;
	assign bus.m_sda_oe = sda_low;
endmodule

// file: dv/frm_link_chk.sv
// Protocol checker for the two-wire link between master and memory.
`timescale 1ns/1ns
module frm_link_chk (
	input wire logic clk,
	input wire logic srst,
	input wire logic scl,
	input wire logic sda,
	input wire logic m_scl_o,
	input wire logic m_scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic d_sda_o,
	input wire logic d_sda_oe,
	input wire logic hs_mode,
	input wire logic active
);
	// ============================================================
	// Line events
	// Raw line edges are used on purpose: the memory filters its inputs, so
	// every bound below leaves room for that latency.
	logic bus_start;
	logic bus_stop;
	logic sda_prev_hi_scl;
	logic sda_prev_lo_n;
	assign bus_start = scl & sda_prev_hi_scl & ~sda;
	assign bus_stop = scl & sda & ~sda_prev_lo_n;
	always_ff @(posedge clk) begin
		sda_prev_hi_scl <= scl & sda;
		sda_prev_lo_n <= ~(scl & ~sda);
	end

	// ============================================================
	// Link properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_reset_lines_free: assert property (
		disable iff (1'b0) srst |=> !m_scl_oe && !m_sda_oe && !d_sda_oe)
		else $error("link line pulled low during reset");
	// Both ends may only sink a line; a driven high would fight the pull-up.
	a_drive_low_only: assert property (
		!m_scl_o && !m_sda_o && !d_sda_o)
		else $error("link driver presents a high level");
	a_mem_edge_fall: assert property (
		d_sda_oe != $past(d_sda_oe) |-> !scl)
		else $error("memory changed data while clock high");
	a_hs_code_unacked: assert property (
		$rose(hs_mode) |-> !d_sda_oe [*8])
		else $error("memory acknowledged the speed code");
	a_hs_ends_stop: assert property (
		$fell(hs_mode) |-> scl && sda)
		else $error("fast mode left without a stop");
	a_hs_clears_stop: assert property (
		bus_stop && hs_mode |-> ##[1:8] !hs_mode)
		else $error("fast mode kept after stop");
	a_start_mem_quiet: assert property (
		bus_start |-> !d_sda_oe ##1 !d_sda_oe)
		else $error("memory drives data across a start");
	a_stop_goes_idle: assert property (
		bus_stop |-> ##[1:8] !active)
		else $error("memory not idle after stop");
	a_select_after_start: assert property (
		$rose(active) |-> !sda && scl)
		else $error("memory woke without a start");
endmodule

// file: dv/i2c_fram_read_and_hs_mode_test.sv
// Self-checking bench: master and memory joined across the two-wire link.
`timescale 1ns/1ns
module i2c_fram_read_and_hs_mode_test;
	// ============================================================
	// Clock, stimulus and design
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic load_en = 1'b0;
	logic [12:0] load_addr = 13'h0000;
	logic [7:0] load_data = 8'h00;
	logic cmd_valid = 1'b0;
	logic cmd_random = 1'b0;
	logic cmd_hs = 1'b0;
	logic [2:0] cmd_cs = 3'h5;
	logic [12:0] cmd_addr = 13'h0000;
	logic [7:0] cmd_len = 8'h00;
	logic cmd_ready, rd_valid, done, nack_err, hs_mode, active;
	logic [7:0] rd_data;
	logic [7:0] ref_mem [0:8191];
	logic [12:0] ref_ptr = 13'h0000;
	int miscompares = 0;
	int checks_done = 0;

	always #5 clk = ~clk;

	frm_if frm_if_inst ();
	frm_mem frm_mem_inst (.clk(clk), .srst(srst), .bus(frm_if_inst.mem),
		.chip_select_pins(3'h5), .load_en(load_en), .load_addr(load_addr),
		.load_data(load_data), .hs_mode(hs_mode), .active(active));
	frm_master frm_master_inst (.clk(clk), .srst(srst),
		.bus(frm_if_inst.master), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_random(cmd_random), .cmd_hs(cmd_hs),
		.cmd_cs(cmd_cs), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
		.rd_valid(rd_valid), .rd_data(rd_data), .done(done),
		.nack_err(nack_err));
	frm_link_chk frm_link_chk_inst (.clk(clk), .srst(srst),
		.scl(frm_if_inst.scl), .sda(frm_if_inst.sda),
		.m_scl_o(frm_if_inst.m_scl_o), .m_scl_oe(frm_if_inst.m_scl_oe),
		.m_sda_o(frm_if_inst.m_sda_o), .m_sda_oe(frm_if_inst.m_sda_oe),
		.d_sda_o(frm_if_inst.d_sda_o), .d_sda_oe(frm_if_inst.d_sda_oe),
		.hs_mode(hs_mode), .active(active));

	// ============================================================
	// Access tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic load_byte(input logic [12:0] a, input logic [7:0] d);
		@(negedge clk);
		load_en = 1'b1;
		load_addr = a;
		load_data = d;
		ref_mem[a] = d;
		@(negedge clk);
		load_en = 1'b0;
	endtask

	// A select value other than the wired one must be refused, so the
	// expected byte count and error flag follow from the select alone.
	task automatic read_seq(input string name, input logic rnd,
		input logic hs, input logic [2:0] cs, input logic [12:0] a,
		input logic [7:0] n);
		logic [12:0] p;
		logic [7:0] got;
		logic saw_hs;
		logic fin;
		logic bad;
		bad = (cs !== 3'h5);
		p = rnd ? a : ref_ptr;
		got = 8'h00;
		saw_hs = 1'b0;
		fin = 1'b0;
		@(negedge clk);
		check({7'h00, cmd_ready}, 8'h01);
		cmd_valid = 1'b1;
		cmd_random = rnd;
		cmd_hs = hs;
		cmd_cs = cs;
		cmd_addr = a;
		cmd_len = n;
		@(negedge clk);
		cmd_valid = 1'b0;
		for (int i = 0; i < 40000 && !fin; i++) begin
			@(negedge clk);
			if (rd_valid === 1'b1) begin
				check(rd_data, ref_mem[p]);
				p = p + 13'h0001;
				got = got + 8'h01;
			end
			if (hs_mode === 1'b1)
				saw_hs = 1'b1;
			fin = (done === 1'b1);
		end
		check({7'h00, fin}, 8'h01);
		check(got, bad ? 8'h00 : n);
		check({7'h00, nack_err}, {7'h00, bad});
		check({7'h00, saw_hs}, {7'h00, hs});
		@(negedge clk);
		check({7'h00, hs_mode}, 8'h00);
		if (!bad)
			ref_ptr = p;
		$display("test %s finished", name);
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ============================================================
	// Tests
	initial begin
		repeat (20) @(negedge clk);
		srst = 1'b0;
		load_byte(13'h0010, 8'hA5);
		load_byte(13'h0011, 8'h3C);
		load_byte(13'h1FFE, 8'h11);
		load_byte(13'h1FFF, 8'h22);
		load_byte(13'h0000, 8'h33);
		load_byte(13'h0001, 8'h44);
		load_byte(13'h0100, 8'h5A);
		load_byte(13'h0101, 8'hC3);
		load_byte(13'h0102, 8'h96);
		read_seq("random", 1'b1, 1'b0, 3'h5, 13'h0010, 8'h01);
		read_seq("current", 1'b0, 1'b0, 3'h5, 13'h0000, 8'h01);
		read_seq("wrap", 1'b1, 1'b0, 3'h5, 13'h1FFE, 8'h03);
		read_seq("fast current", 1'b0, 1'b1, 3'h5, 13'h0000, 8'h01);
		read_seq("fast random", 1'b1, 1'b1, 3'h5, 13'h0100, 8'h02);
		read_seq("bad select", 1'b1, 1'b0, 3'h2, 13'h0200, 8'h01);
		read_seq("after refusal", 1'b0, 1'b0, 3'h5, 13'h0000, 8'h01);
		stop_test();
	end

	// Seven transfers take a little over half of this span.
	initial begin
		repeat (90000) @(posedge clk);
		miscompares++;
		stop_test();
	end
endmodule
